// ==== common/bobu_pkg.sv ====
// Shared constants and types of the bit operation and branch unit.
// Assumes a 32-bit datapath and a stack that grows toward lower addresses.
package bobu_pkg;

    localparam int unsigned DW = 32;

    // Commands issued by the decoder
    typedef enum logic [4:0] {
        OP_BIT_TEST_ONLY,
        OP_BIT_TEST_SET,
        OP_BIT_TEST_CLEAR,
        OP_BIT_TEST_INVERT,
        OP_SCAN_LOW_TO_HIGH,
        OP_SCAN_HIGH_TO_LOW,
        OP_BYTE_ON_CONDITION,
        OP_AND_TEST,
        OP_GOTO_REL,
        OP_GOTO_REG,
        OP_GOTO_FAR,
        OP_GOTO_COND,
        OP_CALL_REL,
        OP_CALL_REG,
        OP_LEAVE_PROCEDURE,
        OP_LEAVE_HANDLER,
        OP_ENTER_HANDLER
    } bobu_op_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PUSH2,
        S_WAIT1,
        S_TAKE1,
        S_WAIT2,
        S_TAKE2
    } bobu_state_t;

    // Flag bit positions inside flags_register
    localparam int unsigned FLAG_CARRY = 0;
    localparam int unsigned FLAG_PARITY = 2;
    localparam int unsigned FLAG_ZERO = 6;
    localparam int unsigned FLAG_SIGN = 7;
    localparam int unsigned FLAG_OVERFLOW = 11;

    // Condition code that tests overflow_flag
    localparam logic [3:0] CC_OVERFLOW = 4'h0;

    localparam logic [31:0] STACK_STEP = 32'h0000_0004;

    localparam logic [31:0] IP_RESET = 32'h0000_0000;
    localparam logic [31:0] SP_RESET = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [15:0] CS_RESET = 16'h0000;

    // Register port byte offsets
    localparam logic [3:0] REG_IP = 4'h0;
    localparam logic [3:0] REG_SP = 4'h4;
    localparam logic [3:0] REG_FLAGS = 4'h8;
    localparam logic [3:0] REG_CS = 4'hc;

endpackage

// ==== src/bobu_bit_scan.sv ====
// Priority finders for the lowest and highest set bit of a word.
// Purely combinational; the caller registers the results.
module bobu_bit_scan
    import bobu_pkg::*;
(
    input wire logic [31:0] src_in,
    output logic [4:0] low_idx_out,
    output logic [4:0] high_idx_out,
    output logic none_out
);

    wire [4:0] lo_c [0:32];
    wire [4:0] hi_c [0:32];

    assign lo_c[32] = 5'h00;
    assign hi_c[0] = 5'h00;

    // Low chain lets lower bits override, high chain lets higher bits override
    for (genvar i = 0; i < 32; i++) begin : g_bit
        assign lo_c[i] = src_in[i] ? 5'(i) : lo_c[i + 1];
        assign hi_c[i + 1] = src_in[i] ? 5'(i) : hi_c[i];
    end

    always_comb begin
        low_idx_out = lo_c[0];
        high_idx_out = hi_c[32];
        none_out = (src_in == 32'h0000_0000);
    end

endmodule

// ==== src/bobu_cond_eval.sv ====
// Evaluates a four-bit condition code against the status flags.
// Even codes test a flag term, odd codes test its inverse.
module bobu_cond_eval
    import bobu_pkg::*;
(
    input wire logic [31:0] flags_in,
    input wire logic [3:0] cc_in,
    output logic true_out
);

    logic carry, zero, sign, ovf, par;
    logic base;

    always_comb begin
        carry = flags_in[FLAG_CARRY];
        zero = flags_in[FLAG_ZERO];
        sign = flags_in[FLAG_SIGN];
        ovf = flags_in[FLAG_OVERFLOW];
        par = flags_in[FLAG_PARITY];
        unique case (cc_in[3:1])
            3'h0: base = ovf;
            3'h1: base = carry;
            3'h2: base = zero;
            3'h3: base = carry | zero;
            3'h4: base = sign;
            3'h5: base = par;
            3'h6: base = sign ^ ovf;
            3'h7: base = (sign ^ ovf) | zero;
        endcase
        true_out = base ^ cc_in[0];
    end

endmodule

// ==== src/bobu_core.sv ====
// Bit operation and control transfer unit between decoder, register file and stack.
// Assumes stack memory takes a request in one cycle and returns read data the cycle after.
module bobu_core
    import bobu_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire bobu_op_t cmd_op_in,
    input wire logic [31:0] operand_a_in,
    input wire logic [31:0] operand_b_in,
    input wire logic [31:0] next_ip_in,
    input wire logic [3:0] cond_in,
    input wire logic [15:0] imm_in,
    input wire logic [15:0] far_sel_in,
    output logic busy_out,
    output logic res_we_out,
    output logic [31:0] res_data_out,
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic [31:0] mem_rdata_in,
    output logic [31:0] ip_out,
    output logic [31:0] sp_out,
    output logic [31:0] flags_out,
    output logic [15:0] cs_out,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out
);

    bobu_state_t st_q, st_d;
    bobu_op_t op_q;
    logic [31:0] ip_q, sp_q, flags_q;
    logic [15:0] cs_q, imm_q;
    logic [31:0] tgt_q, ret_ip_q;
    logic busy_q, res_we_q;
    logic [31:0] res_data_q;
    logic mem_req_q, mem_we_q;
    logic [31:0] mem_addr_q, mem_wdata_q;
    logic [31:0] reg_rdata_q;

    logic go;
    logic [4:0] ofs;
    logic sel_bit;
    logic [31:0] bit_mask, modified, and_res, rel_tgt;
    logic [4:0] low_idx, high_idx;
    logic scan_none, cond_true, of_flag;
    logic is_bitop, is_push_call, is_pop;

    assign ip_out = ip_q;
    assign sp_out = sp_q;
    assign flags_out = flags_q;
    assign cs_out = cs_q;
    assign busy_out = busy_q;
    assign res_we_out = res_we_q;
    assign res_data_out = res_data_q;
    assign mem_req_out = mem_req_q;
    assign mem_we_out = mem_we_q;
    assign mem_addr_out = mem_addr_q;
    assign mem_wdata_out = mem_wdata_q;
    assign reg_rdata_out = reg_rdata_q;

    bobu_bit_scan u_scan (
        .src_in(operand_a_in),
        .low_idx_out(low_idx),
        .high_idx_out(high_idx),
        .none_out(scan_none)
    );

    bobu_cond_eval u_cond (
        .flags_in(flags_q),
        .cc_in(cond_in),
        .true_out(cond_true)
    );

    // Commands are only taken while idle; the decoder must watch busy_out
    always_comb begin
        go = cmd_valid_in && (st_q == S_IDLE);
        ofs = operand_b_in[4:0];
        sel_bit = operand_a_in[ofs];
        bit_mask = 32'h0000_0001 << ofs;
        and_res = operand_a_in & operand_b_in;
        rel_tgt = next_ip_in + operand_b_in;
        of_flag = flags_q[FLAG_OVERFLOW];
        is_bitop = (cmd_op_in == OP_BIT_TEST_ONLY) || (cmd_op_in == OP_BIT_TEST_SET)
            || (cmd_op_in == OP_BIT_TEST_CLEAR) || (cmd_op_in == OP_BIT_TEST_INVERT);
        is_push_call = (cmd_op_in == OP_CALL_REL) || (cmd_op_in == OP_CALL_REG);
        is_pop = (cmd_op_in == OP_LEAVE_PROCEDURE) || (cmd_op_in == OP_LEAVE_HANDLER);
        modified = operand_a_in;
        if (cmd_op_in == OP_BIT_TEST_SET) begin
            modified = operand_a_in | bit_mask;
        end else if (cmd_op_in == OP_BIT_TEST_CLEAR) begin
            modified = operand_a_in & ~bit_mask;
        end else if (cmd_op_in == OP_BIT_TEST_INVERT) begin
            modified = operand_a_in ^ bit_mask;
        end
    end

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE: begin
                if (go && cmd_op_in == OP_ENTER_HANDLER) begin
                    st_d = S_PUSH2;
                end else if (go && is_pop) begin
                    st_d = S_WAIT1;
                end
            end
            S_PUSH2: st_d = S_IDLE;
            S_WAIT1: st_d = S_TAKE1;
            S_TAKE1: st_d = (op_q == OP_LEAVE_HANDLER) ? S_WAIT2 : S_IDLE;
            S_WAIT2: st_d = S_TAKE2;
            S_TAKE2: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= S_IDLE;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            busy_q <= (st_d != S_IDLE);
        end
    end

    // Command context kept for the multi-cycle stack sequences
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_q <= OP_BIT_TEST_ONLY;
            imm_q <= 16'h0000;
            tgt_q <= 32'h0000_0000;
            ret_ip_q <= 32'h0000_0000;
        end else if (go) begin
            op_q <= cmd_op_in;
            imm_q <= imm_in;
            tgt_q <= operand_b_in;
            ret_ip_q <= next_ip_in;
        end
    end

    // Hardware updates win over a software write in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ip_q <= IP_RESET;
        end else if (go) begin
            if (cmd_op_in == OP_GOTO_REL || cmd_op_in == OP_CALL_REL) begin
                ip_q <= rel_tgt;
            end else if (cmd_op_in == OP_GOTO_REG || cmd_op_in == OP_CALL_REG) begin
                ip_q <= operand_a_in;
            end else if (cmd_op_in == OP_GOTO_FAR) begin
                ip_q <= operand_b_in;
            end else if (cmd_op_in == OP_GOTO_COND) begin
                ip_q <= cond_true ? rel_tgt : next_ip_in;
            end else if (!is_pop && cmd_op_in != OP_ENTER_HANDLER) begin
                ip_q <= next_ip_in;
            end
        end else if (st_q == S_PUSH2) begin
            ip_q <= tgt_q;
        end else if (st_q == S_TAKE1) begin
            ip_q <= mem_rdata_in;
        end else if (reg_wr_in && reg_addr_in == REG_IP) begin
            ip_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sp_q <= SP_RESET;
        end else if (go && (is_push_call || cmd_op_in == OP_ENTER_HANDLER)) begin
            sp_q <= sp_q - STACK_STEP;
        end else if (st_q == S_PUSH2) begin
            sp_q <= sp_q - STACK_STEP;
        end else if (st_q == S_TAKE1 && op_q == OP_LEAVE_PROCEDURE) begin
            sp_q <= sp_q + STACK_STEP + {16'h0000, imm_q};
        end else if (st_q == S_TAKE1 || st_q == S_TAKE2) begin
            sp_q <= sp_q + STACK_STEP;
        end else if (reg_wr_in && reg_addr_in == REG_SP) begin
            sp_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cs_q <= CS_RESET;
        end else if (go && cmd_op_in == OP_GOTO_FAR) begin
            cs_q <= far_sel_in;
        end else if (reg_wr_in && reg_addr_in == REG_CS) begin
            cs_q <= reg_wdata_in[15:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_q <= FLAGS_RESET;
        end else if (go && is_bitop) begin
            flags_q[FLAG_CARRY] <= sel_bit;
        end else if (go && (cmd_op_in == OP_SCAN_LOW_TO_HIGH || cmd_op_in == OP_SCAN_HIGH_TO_LOW)) begin
            flags_q[FLAG_ZERO] <= scan_none;
        end else if (go && cmd_op_in == OP_AND_TEST) begin
            flags_q[FLAG_SIGN] <= and_res[31];
            flags_q[FLAG_ZERO] <= (and_res == 32'h0000_0000);
            flags_q[FLAG_PARITY] <= ~^and_res[7:0];
            flags_q[FLAG_CARRY] <= 1'b0;
            flags_q[FLAG_OVERFLOW] <= 1'b0;
        end else if (st_q == S_TAKE2) begin
            flags_q <= mem_rdata_in;
        end else if (reg_wr_in && reg_addr_in == REG_FLAGS) begin
            flags_q <= reg_wdata_in;
        end
    end

    // Destination write-back; a scan of zero leaves the destination alone
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            res_we_q <= 1'b0;
            res_data_q <= 32'h0000_0000;
        end else begin
            res_we_q <= 1'b0;
            if (go) begin
                if (is_bitop && cmd_op_in != OP_BIT_TEST_ONLY) begin
                    res_we_q <= 1'b1;
                    res_data_q <= modified;
                end else if (cmd_op_in == OP_SCAN_LOW_TO_HIGH && !scan_none) begin
                    res_we_q <= 1'b1;
                    res_data_q <= {27'h0, low_idx};
                end else if (cmd_op_in == OP_SCAN_HIGH_TO_LOW && !scan_none) begin
                    res_we_q <= 1'b1;
                    res_data_q <= {27'h0, high_idx};
                end else if (cmd_op_in == OP_BYTE_ON_CONDITION) begin
                    res_we_q <= 1'b1;
                    res_data_q <= {31'h0, cond_true};
                end
            end
        end
    end

    // Stack port: one access per cycle, outputs registered
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_wdata_q <= 32'h0000_0000;
        end else begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            if (go && is_push_call) begin
                mem_req_q <= 1'b1;
                mem_we_q <= 1'b1;
                mem_addr_q <= sp_q - STACK_STEP;
                mem_wdata_q <= next_ip_in;
            end else if (go && cmd_op_in == OP_ENTER_HANDLER) begin
                mem_req_q <= 1'b1;
                mem_we_q <= 1'b1;
                mem_addr_q <= sp_q - STACK_STEP;
                mem_wdata_q <= flags_q;
            end else if (st_q == S_PUSH2) begin
                mem_req_q <= 1'b1;
                mem_we_q <= 1'b1;
                mem_addr_q <= sp_q - STACK_STEP;
                mem_wdata_q <= ret_ip_q;
            end else if (go && is_pop) begin
                mem_req_q <= 1'b1;
                mem_addr_q <= sp_q;
            end else if (st_q == S_TAKE1 && op_q == OP_LEAVE_HANDLER) begin
                mem_req_q <= 1'b1;
                mem_addr_q <= sp_q + STACK_STEP;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_IP: reg_rdata_q <= ip_q;
                REG_SP: reg_rdata_q <= sp_q;
                REG_FLAGS: reg_rdata_q <= flags_q;
                REG_CS: reg_rdata_q <= {16'h0000, cs_q};
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    AST_BIT_CARRY: assert property (
        go && is_bitop |=> flags_q[FLAG_CARRY] == $past(sel_bit)
    ) else $error("carry does not hold the tested bit");

    AST_BIT_SET: assert property (
        go && cmd_op_in == OP_BIT_TEST_SET |=>
            res_we_out && res_data_out == ($past(operand_a_in) | $past(bit_mask))
    ) else $error("set variant wrote a wrong word");

    AST_BIT_ONLY: assert property (
        go && cmd_op_in == OP_BIT_TEST_ONLY |=> !res_we_out
    ) else $error("test-only variant wrote its operand");

    AST_SCAN_LOW: assert property (
        go && cmd_op_in == OP_SCAN_LOW_TO_HIGH && !scan_none |=>
            res_we_out && (($past(operand_a_in) >> res_data_out[4:0]) & 32'h1) == 32'h1
            && ($past(operand_a_in) & ((32'h1 << res_data_out[4:0]) - 32'h1)) == 32'h0
    ) else $error("low scan index is not the lowest set bit");

    AST_SCAN_HIGH: assert property (
        go && cmd_op_in == OP_SCAN_HIGH_TO_LOW && !scan_none |=>
            res_we_out && ($past(operand_a_in) >> res_data_out[4:0]) == 32'h1
    ) else $error("high scan index is not the highest set bit");

    AST_BYTE_RANGE: assert property (
        go && cmd_op_in == OP_BYTE_ON_CONDITION |=> res_we_out && res_data_out[31:1] == 31'h0
    ) else $error("condition byte is not 0 or 1");

    AST_BYTE_OVF: assert property (
        go && cmd_op_in == OP_BYTE_ON_CONDITION && cond_in == CC_OVERFLOW |=>
            res_data_out[0] == $past(of_flag)
    ) else $error("overflow byte does not follow the flag");

    AST_AND_TEST: assert property (
        go && cmd_op_in == OP_AND_TEST |=> !res_we_out
            && flags_q[FLAG_ZERO] == ($past(and_res) == 32'h0)
            && flags_q[FLAG_SIGN] == $past(and_res[31])
    ) else $error("and test flags wrong or operand written");

    AST_COND_SKIP: assert property (
        go && cmd_op_in == OP_GOTO_COND && !cond_true |=> ip_q == $past(next_ip_in)
    ) else $error("untaken conditional transfer moved the pointer");

    AST_GOTO_REL: assert property (
        go && cmd_op_in == OP_GOTO_REL |=>
            ip_q == $past(rel_tgt) && !mem_req_out && sp_q == $past(sp_q)
    ) else $error("relative goto target or stack wrong");

    AST_CALL_PUSH: assert property (
        go && cmd_op_in == OP_CALL_REL |=> mem_we_out
            && mem_addr_out == $past(sp_q) - STACK_STEP && mem_wdata_out == $past(next_ip_in)
            && sp_q == mem_addr_out
    ) else $error("call did not push the return pointer");

    AST_LEAVE_PROC: assert property (
        st_q == S_TAKE1 && op_q == OP_LEAVE_PROCEDURE |=> ip_q == $past(mem_rdata_in)
            && sp_q == $past(sp_q) + STACK_STEP + {16'h0000, $past(imm_q)}
    ) else $error("return did not restore pointer and stack");

    AST_ENTER_PUSH: assert property (
        go && cmd_op_in == OP_ENTER_HANDLER |=> mem_we_out && mem_wdata_out == $past(flags_q)
            ##1 mem_we_out && mem_wdata_out == $past(ret_ip_q, 1) && busy_out == 1'b0
    ) else $error("handler entry did not push flags then pointer");

    AST_LEAVE_HANDLER: assert property (
        go && cmd_op_in == OP_LEAVE_HANDLER |=> ##4 flags_q == $past(mem_rdata_in)
    ) else $error("handler return did not restore flags");

endmodule

// ==== verification/bobu_stack_model.sv ====
// Behavioural stack memory on the far side of the unit.
// Takes a request in one cycle; read data stand only in the following cycle.
module bobu_stack_model (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [31:0]];

    initial rdata_out = 32'h0;

    always @(posedge clk_in) begin
        if (req_in && we_in) begin
            mem[addr_in] = wdata_in;
        end
        if (req_in && !we_in) begin
            rdata_out <= mem.exists(addr_in) ? mem[addr_in] : 32'hbad0_0bad;
        end else begin
            // Outside the answer cycle the bus toggles, showing the complement and the stale word by turns
            rdata_out <= ~rdata_out;
        end
    end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the bit operation and branch unit.
// Assumes bobu_pkg encodings and a one-cycle stack model on the memory port.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bobu_pkg::*;
    logic clk = 0, rst = 1, vld = 0, wr = 0, rd = 0;
    bobu_op_t op = OP_BIT_TEST_ONLY;
    logic [31:0] a = 0, b = 0, nip = 0, wd = 0, f, e, rdat, mrd;
    logic [3:0] cc = 0, ra = 0;
    logic [15:0] im = 0;
    logic busy, rwe, mreq, mwe;
    logic [31:0] res, maddr, mwd, ip, sp, fl;
    logic [15:0] cs;
    int miscompares = 0, samples_checked = 0, s;

    always #20 clk = ~clk;

    bobu_core bobu_core_inst (.clk_in(clk), .rst_in(rst), .cmd_valid_in(vld), .cmd_op_in(op),
        .operand_a_in(a), .operand_b_in(b), .next_ip_in(nip), .cond_in(cc), .imm_in(im),
        .far_sel_in(a[15:0]), .busy_out(busy), .res_we_out(rwe), .res_data_out(res),
        .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd),
        .mem_rdata_in(mrd), .ip_out(ip), .sp_out(sp), .flags_out(fl), .cs_out(cs),
        .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat));
    bobu_stack_model bobu_stack_model_inst (.clk_in(clk), .req_in(mreq), .we_in(mwe),
        .addr_in(maddr), .wdata_in(mwd), .rdata_out(mrd));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Issue one command; returns just after the edge where its results land
    task automatic cmd(input bobu_op_t o, input logic [31:0] x, y, n, input logic [3:0] c = 0,
                       input logic [15:0] i = 0);
        @(posedge clk);
        vld <= 1; op <= o; a <= x; b <= y; nip <= n; cc <= c; im <= i;
        @(posedge clk);
        vld <= 0;
        #1;
    endtask

    task automatic settle();
        int k;
        for (k = 0; k < 20 && busy !== 1'b0; k++) @(posedge clk);
        if (busy !== 1'b0) begin
            miscompares++;
            conclude();
        end
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] ad, input logic [31:0] v);
        @(posedge clk);
        wr <= 1; ra <= ad; wd <= v;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask

    task automatic reg_rd(input logic [3:0] ad, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1; ra <= ad;
        @(posedge clk);
        rd <= 0;
        #1;
        chk("reg read", rdat, exp);
    endtask

    function automatic logic [31:0] scan(input logic [31:0] v, input bit up);
        for (int k = 0; k < 32; k++) if (v[up ? k : 31 - k]) return up ? k : 31 - k;
        return 0;
    endfunction

    function automatic logic cond(input logic [31:0] g, input logic [3:0] c);
        logic t;
        case (c[3:1])
            0: t = g[11];
            1: t = g[0];
            2: t = g[6];
            3: t = g[0] | g[6];
            4: t = g[7];
            5: t = g[2];
            6: t = g[7] ^ g[11];
            default: t = (g[7] ^ g[11]) | g[6];
        endcase
        return t ^ c[0];
    endfunction

    initial begin
        s = $urandom(90911);
        repeat (20) @(posedge clk);
        rst <= 0;
        reg_rd(REG_IP, IP_RESET);
        reg_rd(REG_SP, SP_RESET);
        reg_rd(REG_FLAGS, FLAGS_RESET);
        reg_rd(REG_CS, {16'h0000, CS_RESET});
        reg_rd(4'h2, 32'h0000_0000);
        for (int i = 0; i < 32; i++) begin
            f = $urandom;
            cmd(bobu_op_t'(i % 4), f, ($urandom & 32'hffff_ffe0) | i, 0);
            e = f;
            e[i] = (i % 4 == 1) ? 1'b1 : (i % 4 == 2) ? 1'b0 : (i % 4 == 3) ? ~f[i] : f[i];
            chk("bit carry", fl[FLAG_CARRY], f[i]);
            chk("bit write", rwe, i % 4 != 0);
            if (i % 4 != 0) chk("bit result", res, e);
        end
        for (int i = 0; i < 24; i++) begin
            f = (i == 0) ? 0 : (i == 1) ? 32'h8000_0000 : $urandom >> ($urandom % 32);
            cmd(i % 2 ? OP_SCAN_HIGH_TO_LOW : OP_SCAN_LOW_TO_HIGH, f, 0, 0);
            chk("scan write", rwe, f != 0);
            chk("scan zero", fl[FLAG_ZERO], f == 0);
            if (f != 0) chk("scan index", res, scan(f, i % 2 == 0));
        end
        for (int c = 0; c < 16; c++) begin
            f = ($urandom & 32'h8c5) | 32'h2;
            reg_wr(REG_FLAGS, f);
            cmd(OP_BYTE_ON_CONDITION, 0, 0, 0, c);
            chk("byte write", rwe, 1);
            chk("byte value", res[7:0], cond(f, c));
        end
        for (int i = 0; i < 8; i++) begin
            f = $urandom;
            e = i == 0 ? 0 : $urandom;
            cmd(OP_AND_TEST, f, e, 0);
            chk("and sign", fl[FLAG_SIGN], (f & e) >> 31);
            chk("and zero", fl[FLAG_ZERO], (f & e) == 0);
            chk("and parity", fl[FLAG_PARITY], ~^(f[7:0] & e[7:0]));
            chk("and no write", rwe, 0);
        end
        reg_wr(REG_SP, 32'h200);
        cmd(OP_GOTO_REL, 0, 32'hffff_fff0, 32'h1000);
        chk("rel ip", ip, 32'hff0);
        chk("rel no push", mreq, 0);
        chk("rel sp", sp, 32'h200);
        f = $urandom;
        cmd(OP_GOTO_REG, f, 0, 32'h44);
        chk("reg ip", ip, f);
        cmd(OP_GOTO_FAR, 32'h7733, 32'h3210, 32'h44);
        chk("far ip", ip, 32'h3210);
        chk("far cs", cs, 32'h7733);
        for (int c = 0; c < 16; c++) begin
            f = ($urandom & 32'h8c5) | 32'h2;
            reg_wr(REG_FLAGS, f);
            cmd(OP_GOTO_COND, 0, 32'h20, 32'h2000, c);
            chk("cond ip", ip, cond(f, c) ? 32'h2020 : 32'h2000);
        end
        cmd(OP_CALL_REL, 0, 32'h100, 32'h1234);
        chk("call push", {mreq, mwe}, 2'b11);
        chk("call addr", maddr, 32'h1fc);
        chk("call data", mwd, 32'h1234);
        settle();
        chk("call ip", ip, 32'h1334);
        cmd(OP_CALL_REG, 32'h8000, 0, 32'h1340);
        settle();
        chk("callr ip", ip, 32'h8000);
        chk("callr sp", sp, 32'h1f8);
        cmd(OP_LEAVE_PROCEDURE, 0, 0, 0);
        settle();
        chk("ret ip", ip, 32'h1340);
        chk("ret sp", sp, 32'h1fc);
        cmd(OP_LEAVE_PROCEDURE, 0, 0, 0, 0, 16'h8);
        settle();
        chk("reti ip", ip, 32'h1234);
        chk("reti sp", sp, 32'h208);
        reg_wr(REG_FLAGS, 32'h8c3);
        cmd(OP_ENTER_HANDLER, 0, 32'h9000, 32'h5000);
        chk("int flags push", {mreq, mwe}, 2'b11);
        chk("int flags addr", maddr, 32'h204);
        chk("int flags data", mwd, 32'h8c3);
        settle();
        chk("int ip", ip, 32'h9000);
        chk("int sp", sp, 32'h200);
        reg_wr(REG_FLAGS, 32'h2);
        cmd(OP_LEAVE_HANDLER, 0, 0, 0);
        settle();
        chk("leave_handler ip", ip, 32'h5000);
        chk("leave_handler flags", fl, 32'h8c3);
        reg_rd(REG_SP, 32'h208);
        conclude();
    end
endmodule
